/* include/ssms_pkg.sv */
// What this block does
// - default mode is master, driving the shared sync line at selected frequency.
// - a slave following a master device switches half a period out of phase.
// - a slave following an external reference switches in phase with it.
// - in slave mode the oscillator runs at 250 kHz and drives the line.
// - ten sync pulses above 275 kHz (550 kHz with the 500 kHz strap) switch the device into slave mode.
// - slope compensation setting latched at power-up and held fixed afterwards.
// - stay slave while line above 275 kHz (550 kHz with the 500 kHz strap), else one 250 kHz pulse, then master.
// - line low at power-up latches slave mode at 250 kHz until lockout.
// - frequency strap sampled once at power-up, then the pin floats.
//
// Purpose : constants and types of the sync master/slave controller
// Assumes : 100 MHz system clock
// Notes   : frequency select strap is a one-bit code, 250 kHz or 500 kHz
package ssms_pkg;
   localparam int unsigned CLK_HZ         = 100_000_000;
   localparam int unsigned SLAVE_FREQ_HZ  = 250_000;
   localparam int unsigned FAST_FREQ_HZ   = 500_000;
   localparam int unsigned SPREAD_PCT     = 10;
   localparam int unsigned CNT_W          = 16;
   localparam int unsigned PULSE_NS       = 340;
   localparam int unsigned NS_PER_S       = 1_000_000_000;
   // oscillator periods in system cycles
   localparam logic [CNT_W-1:0] PER_SLOW  = CNT_W'(CLK_HZ / SLAVE_FREQ_HZ);
   localparam logic [CNT_W-1:0] PER_FAST  = CNT_W'(CLK_HZ / FAST_FREQ_HZ);
   // fastest own period: typ period less spread (250k -> 275k top)
   localparam logic [CNT_W-1:0] LIM_SLOW  =
      CNT_W'((CLK_HZ / SLAVE_FREQ_HZ) * 100 / (100 + SPREAD_PCT));
   localparam logic [CNT_W-1:0] LIM_FAST  =
      CNT_W'((CLK_HZ / FAST_FREQ_HZ) * 100 / (100 + SPREAD_PCT));
   // drive pulse width, minimum on-time rounded up
   localparam logic [CNT_W-1:0] PULSE_CYC =
      CNT_W'((PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
   localparam logic [3:0] DETECT_PULSES   = 4'ha;
   localparam logic       FSEL_250K       = 1'b0;

   typedef enum logic [1:0] {
      SSMS_STRAP,
      SSMS_MASTER,
      SSMS_SLAVE,
      SSMS_EXIT
   } ssms_mode_t;

   typedef struct packed {
      logic fsel;
      logic forced_slave;
   } ssms_strap_t;
endpackage : ssms_pkg

/* src/ssms_sync_ctrl.sv */
// Purpose : master/slave sync line logic for a switching regulator oscillator
// Assumes : line samples cross two flops; undervoltage lockout acts as reset
// Notes   : slave phase follows the line; own master pulses come from the counter
`timescale 1ns/1ns
module ssms_sync_ctrl (
   // clock and reset
   input  wire logic                 clk_sys_i,
   input  wire logic                 rstn_i,
   // power-up sequencing
   input  wire logic                 soft_start_i,
   // frequency select strap pin
   input  wire logic                 freq_select_pin_i,
   output logic                      freq_select_oe_n_o,
   // shared sync line
   input  wire logic                 shared_sync_line_i,
   output logic                      shared_sync_line_o,
   output logic                      shared_sync_line_oe_n_o,
   // oscillator and status
   output logic                      sw_start_o,
   output logic                      slave_mode_o,
   output logic                      slope_fsel_o
);
   // synchronisers
   logic [1:0] sync_line_r, sync_fsel_r;
   logic       line_d_r;
   // state
   ssms_pkg::ssms_mode_t        mode_r, mode_nxt;
   ssms_pkg::ssms_strap_t       strap_r, strap_nxt;
   logic [ssms_pkg::CNT_W-1:0]  osc_r, osc_nxt;
   logic [ssms_pkg::CNT_W-1:0]  gap_r, gap_nxt;
   logic [3:0]                  pcnt_r, pcnt_nxt;
   logic                        strapped_r, strapped_nxt;
   logic                        sw_r, sw_nxt;
   logic                        drv_r, drv_nxt;
   logic [ssms_pkg::CNT_W-1:0]  per, lim;
   logic                        rise, rise_ext, osc_wrap, drv_go;
   logic [ssms_pkg::CNT_W-1:0]  wid_r, wid_nxt;

   // two flops before any logic reads the pins
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync_line_r <= 2'h3;
         sync_fsel_r <= 2'h0;
         line_d_r    <= 1'h1;
      end else begin
         sync_line_r <= {sync_line_r[0], shared_sync_line_i};
         sync_fsel_r <= {sync_fsel_r[0], freq_select_pin_i};
         line_d_r    <= sync_line_r[1];
      end
   end

   assign rise = sync_line_r[1] & ~line_d_r;

   // a slave's own drive pulse echoes back two flops later; only idle-time rises are external
   assign rise_ext = rise & ~drv_r;

   // oscillator period: forced slave and slave run slow
   always_comb begin
      if (strap_r.forced_slave || mode_r == ssms_pkg::SSMS_SLAVE ||
          mode_r == ssms_pkg::SSMS_EXIT || strap_r.fsel == ssms_pkg::FSEL_250K) begin
         per = ssms_pkg::PER_SLOW;
      end else begin
         per = ssms_pkg::PER_FAST;
      end
      lim = (strap_r.fsel == ssms_pkg::FSEL_250K || strap_r.forced_slave) ?
            ssms_pkg::LIM_SLOW : ssms_pkg::LIM_FAST;
   end

   assign osc_wrap = (osc_r >= per - 16'h0001);

   // mode, strap, detection and oscillator next values
   always_comb begin
      mode_nxt     = mode_r;
      strap_nxt    = strap_r;
      strapped_nxt = strapped_r;
      pcnt_nxt     = pcnt_r;
      gap_nxt      = (gap_r == 16'hffff) ? gap_r : gap_r + 16'h0001;
      osc_nxt      = osc_wrap ? 16'h0000 : osc_r + 16'h0001;
      sw_nxt       = 1'b0;
      drv_nxt      = drv_r;
      wid_nxt      = wid_r;
      drv_go       = 1'b0;
      unique case (mode_r)
         ssms_pkg::SSMS_STRAP: begin
            osc_nxt = 16'h0000;
            if (soft_start_i && !strapped_r) begin
               strap_nxt.fsel         = sync_fsel_r[1];
               strap_nxt.forced_slave = ~sync_line_r[1];
               strapped_nxt           = 1'b1;
               mode_nxt = sync_line_r[1] ? ssms_pkg::SSMS_MASTER : ssms_pkg::SSMS_SLAVE;
            end
         end
         ssms_pkg::SSMS_MASTER: begin
            if (osc_wrap) begin
               sw_nxt = 1'b1;
            end
            // line pulse half a period after own start
            if (osc_r == (per >> 1) - 16'h0001) begin
               drv_go = 1'b1;
            end
            if (rise) begin
               gap_nxt = 16'h0000;
               if (gap_r > lim) begin
                  pcnt_nxt = 4'h1;
               end else if (pcnt_r + 4'h1 >= ssms_pkg::DETECT_PULSES) begin
                  pcnt_nxt = 4'h0;
                  mode_nxt = ssms_pkg::SSMS_SLAVE;
               end else begin
                  pcnt_nxt = pcnt_r + 4'h1;
               end
            end
         end
         ssms_pkg::SSMS_SLAVE: begin
            // slave switches on line edge, in phase with the line
            if (rise_ext) begin
               gap_nxt = 16'h0000;
               osc_nxt = 16'h0000;
               sw_nxt  = 1'b1;
               drv_go  = 1'b1;
            end else if (gap_r > lim && !strap_r.forced_slave) begin
               // line too slow, drive one pulse
               mode_nxt = ssms_pkg::SSMS_EXIT;
               osc_nxt  = 16'h0000;
            end else if (strap_r.forced_slave && osc_wrap) begin
               // forced slave keeps driving at the slow rate
               sw_nxt = 1'b1;
               drv_go = 1'b1;
            end
         end
         ssms_pkg::SSMS_EXIT: begin
            if (osc_wrap) begin
               sw_nxt   = 1'b1;
               drv_go   = 1'b1;
               pcnt_nxt = 4'h0;
               mode_nxt = ssms_pkg::SSMS_MASTER;
            end
         end
      endcase
      // line drive pulse of minimum on-time; its own width counter, so a pulse
      // started mid-period is not cut short by the oscillator position
      if (mode_r == ssms_pkg::SSMS_STRAP) begin
         drv_nxt = 1'b0;
         wid_nxt = 16'h0000;
      end else if (drv_go) begin
         drv_nxt = 1'b1;
         wid_nxt = 16'h0000;
      end else if (drv_r) begin
         wid_nxt = wid_r + 16'h0001;
         if (wid_r >= ssms_pkg::PULSE_CYC) begin
            drv_nxt = 1'b0;
         end
      end
   end

   // registers
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode_r     <= ssms_pkg::SSMS_STRAP;
         strap_r    <= '0;
         strapped_r <= 1'b0;
         pcnt_r     <= 4'h0;
         gap_r      <= 16'hffff;
         osc_r      <= 16'h0000;
         sw_r       <= 1'b0;
         drv_r      <= 1'b0;
         wid_r      <= 16'h0000;
      end else begin
         mode_r     <= mode_nxt;
         strap_r    <= strap_nxt;
         strapped_r <= strapped_nxt;
         pcnt_r     <= pcnt_nxt;
         gap_r      <= gap_nxt;
         osc_r      <= osc_nxt;
         sw_r       <= sw_nxt;
         drv_r      <= drv_nxt;
         wid_r      <= wid_nxt;
      end
   end

   // open drain style: drive line high during the drive pulse, release it otherwise
   assign shared_sync_line_o      = drv_r;
   // line driven only during the drive pulse; released in strap and between pulses
   assign shared_sync_line_oe_n_o = (mode_r == ssms_pkg::SSMS_STRAP) | ~drv_r;
   // strap pin floats always (input only)
   assign freq_select_oe_n_o      = 1'b1;
   assign sw_start_o              = sw_r;
   assign slave_mode_o            = (mode_r == ssms_pkg::SSMS_SLAVE);
   assign slope_fsel_o            = strap_r.fsel;

   // assertions
   sequence strap_seen_s;
      mode_r == ssms_pkg::SSMS_STRAP && soft_start_i && !strapped_r;
   endsequence

   strap_latch_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      strapped_r |=> $stable(strap_r)) else $error("strap changed after latch");
   forced_slave_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      strap_r.forced_slave && mode_r != ssms_pkg::SSMS_STRAP |-> slave_mode_o)
      else $error("forced slave left slave mode");
   strap_exit_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      strap_seen_s |=> strapped_r && mode_r != ssms_pkg::SSMS_STRAP)
      else $error("strap not taken");
   slave_phase_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      mode_r == ssms_pkg::SSMS_SLAVE && rise_ext |=> sw_start_o)
      else $error("slave missed line edge");
   exit_master_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      mode_r == ssms_pkg::SSMS_EXIT && osc_wrap |=> mode_r == ssms_pkg::SSMS_MASTER)
      else $error("exit did not return to master");
   exit_slow_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      mode_r == ssms_pkg::SSMS_EXIT |-> per == ssms_pkg::PER_SLOW)
      else $error("exit pulse not at slow rate");
   count_bound_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      pcnt_r < ssms_pkg::DETECT_PULSES) else $error("pulse count overrun");
   slow_restart_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      mode_r == ssms_pkg::SSMS_MASTER && rise && gap_r > lim |=> pcnt_r == 4'h1)
      else $error("count not restarted");
   master_tick_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      mode_r == ssms_pkg::SSMS_MASTER && osc_wrap |=> sw_start_o)
      else $error("master missed own period");
   master_half_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      mode_r == ssms_pkg::SSMS_MASTER && osc_wrap |-> !drv_r)
      else $error("master line pulse overlaps own start");
   slave_drive_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      mode_r == ssms_pkg::SSMS_SLAVE && rise_ext |=> drv_r && !shared_sync_line_oe_n_o)
      else $error("slave did not drive the line");
endmodule : ssms_sync_ctrl

/* tb/ssms_peer.sv */
// Purpose : far-side sync clock master for the sync line
// Assumes : line is pulled low when nobody drives it
// Notes   : runs on its own 125 ns tick, unrelated to the system clock
`timescale 1ns/1ns
module ssms_peer (
   // control from the bench
   input  wire logic hold_i,
   input  wire logic run_i,
   // line drive, high or released
   output logic      drv_o
);
   logic       lclk = 1'b0;
   logic       pul  = 1'b0;
   logic [4:0] n    = 5'h00;
   // hold reaches the line at once, so the strap level stands before soft-start
   assign drv_o = hold_i | pul;
   // 125 ns link tick
   always begin
      #62 lclk = 1'b1;
      #63 lclk = 1'b0;
   end
   // fast pulses
   // 27 ticks is about 296 kHz; a 3 tick pulse clears the minimum width
   // 296 kHz leaves the 10% band: entry needs more than the spread top
   always @(posedge lclk) begin
      n   <= (!run_i || n == 5'h1a) ? 5'h00 : n + 5'h01;
      pul <= run_i & (n < 5'h03);
   end
endmodule : ssms_peer

/* tb/switching_sync_master_slave_tb_top.sv */
// Purpose : scenario bench of the sync master/slave controller
// Assumes : line is a wire-or of highs with a pull-down
// Notes   : peer pulses run at about 296 kHz, above the 275 kHz top
`timescale 1ns/1ns
module switching_sync_master_slave_tb_top;
   logic clk_sys_i = 1'b0;
   logic rstn_i, soft_start_i, fsel_pin, hold, run, peer;
   logic fsel_oe_n, line_o, line_oe_n, sw_start, slave_mode, slope_fsel;
   wire  line;
   int   fails       = 0;
   int   checks_done = 0;
   // 100 MHz clock
   always #5 clk_sys_i = ~clk_sys_i;
   // resolved line, released means low
   assign line = peer | (~line_oe_n & line_o);
   ssms_peer i_ssms_peer (.hold_i(hold), .run_i(run), .drv_o(peer));
   ssms_sync_ctrl i_ssms_sync_ctrl (
      .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .soft_start_i(soft_start_i),
      .freq_select_pin_i(fsel_pin), .freq_select_oe_n_o(fsel_oe_n),
      .shared_sync_line_i(line), .shared_sync_line_o(line_o),
      .shared_sync_line_oe_n_o(line_oe_n), .sw_start_o(sw_start),
      .slave_mode_o(slave_mode), .slope_fsel_o(slope_fsel));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys_i);
   endtask : cyc
   // power-up: reset, then straps taken when soft-start rises
   task automatic pwr_up(input logic fs, input logic hi);
      rstn_i <= 1'b0; soft_start_i <= 1'b0; fsel_pin <= fs; hold <= hi; run <= 1'b0;
      cyc(5); rstn_i <= 1'b1; cyc(3); soft_start_i <= 1'b1; cyc(8); hold <= 1'b0; cyc(2);
   endtask : pwr_up
   // cycles to the next switching start, bounded
   task automatic next_sw(output int t);
      t = 0;
      do begin @(negedge clk_sys_i); t++; end while (sw_start !== 1'b1 && t < 2000);
   endtask : next_sw
   task automatic t_master(input logic fs);
      int t;
      pwr_up(fs, 1'b1);
      fsel_pin <= ~fs;
      next_sw(t);
      next_sw(t);
      chk("master", 1'b0, slave_mode);
      chk("period", fs ? ssms_pkg::PER_FAST : ssms_pkg::PER_SLOW, t);
      chk("start_idle", 1'b1, line_oe_n);
      // line pulse lands half a period after the own start
      repeat ((fs ? ssms_pkg::PER_FAST : ssms_pkg::PER_SLOW) / 2 + 3) @(negedge clk_sys_i);
      chk("drive_oe_n", 1'b0, line_oe_n);
      chk("slope", fs, slope_fsel);
      chk("fsel_oe_n", 1'b1, fsel_oe_n);
      $display("test master fsel=%0d done", fs);
   endtask : t_master
   task automatic t_slave;
      int t;
      int k;
      // device takes the 250 kHz setting; peer pulses run above its 275 kHz top
      pwr_up(1'b0, 1'b1);
      run <= 1'b1;
      // own pulses share the line, so entry time varies; wait for it, bounded
      t = 0;
      do begin @(negedge clk_sys_i); t++; end while (slave_mode !== 1'b1 && t < 30 * 338);
      chk("slave", 1'b1, slave_mode);
      @(posedge peer);
      t = 0;
      do begin @(negedge clk_sys_i); t++; end while (sw_start !== 1'b1 && t < 50);
      chk("in_phase", 1'b1, t <= 5);
      // stop only after the pulse ends so it keeps its full width
      cyc(40);
      run <= 1'b0;
      cyc(250);
      chk("hold_slave", 1'b1, slave_mode);
      k = 0;
      // exit starts once the gap passes the limit, then one slow period runs
      repeat (600) begin @(negedge clk_sys_i); k += (sw_start === 1'b1); end
      chk("exit_pulse", 1, k);
      cyc(110);
      chk("back_master", 1'b0, slave_mode);
      $display("test slave entry and exit done");
   endtask : t_slave
   task automatic t_forced;
      int t;
      pwr_up(1'b1, 1'b0);
      chk("forced", 1'b1, slave_mode);
      cyc(1500);
      next_sw(t);
      next_sw(t);
      chk("forced_per", ssms_pkg::PER_SLOW, t);
      chk("forced_stay", 1'b1, slave_mode);
      chk("slope_f", 1'b1, slope_fsel);
      $display("test forced slave done");
   endtask : t_forced
   task automatic wrap_up;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up
   // watchdog, a few times the expected run
   initial begin
      #400_000;
      fails++;
      wrap_up();
   end
   // main sequence
   initial begin
      rstn_i = 1'b0; soft_start_i = 1'b0; fsel_pin = 1'b0; hold = 1'b0; run = 1'b0;
      cyc(5);
      t_master(1'b0);
      t_master(1'b1);
      t_slave();
      t_forced();
      wrap_up();
   end
endmodule : switching_sync_master_slave_tb_top
